// File: core/seq_map.vh
// Purpose: constants shared by the bus-cycle sequencer and its cycle table
// Assumes: one machine state per mclk period
// Notes: definitions only
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

// ********************************************************************
// machine cycle kinds
// ********************************************************************
`define K_END 3'h0
`define K_OPF1 3'h1
`define K_OPF2 3'h2
`define K_OPR 3'h3
`define K_IDLE 3'h4
`define K_RD 3'h5
`define K_WR 3'h6

// ********************************************************************
// address sources shown on addr_sel
// ********************************************************************
`define A_NONE 3'h0
`define A_PC 3'h1
`define A_HL 3'h2
`define A_IXD 3'h3
`define A_BC 3'h4
`define A_DE 3'h5
`define A_MN 3'h6

// ********************************************************************
// instruction classes on instr_class
// ********************************************************************
`define C_JR 4'h0
`define C_JRC 4'h1
`define C_LD_GG 4'h2
`define C_LD_GM 4'h3
`define C_LD_GHL 4'h4
`define C_LD_GIX 4'h5
`define C_LD_HLG 4'h6
`define C_LD_IXG 4'h7
`define C_LD_HLM 4'h8
`define C_LD_IXM 4'h9
`define C_LD_ABC 4'hA
`define C_LD_ADE 4'hB
`define C_LD_AMN 4'hC
`define C_LD_BCA 4'hD
`define C_LD_DEA 4'hE

// ********************************************************************
// timing
// ********************************************************************
`define CLK_PERIOD_PS 5000
`define STATE_TIME_PS 5000

`endif

// File: core/cycle_table.v
// Purpose: machine cycle table of the relative jump and load_move group
// Assumes: step 0 is the first machine cycle of an instruction
// Notes: purely combinational; returns {kind, address source}
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module cycle_table
(
	input wire [3:0] cls,
	input wire [2:0] step,
	input wire cond,
	output wire [2:0] kind,
	output wire [2:0] addr
);

	// ****************************************************************
	// lookup
	// ****************************************************************

	// one entry per machine cycle, END once the list runs out
	function [5:0] entry;
		input [3:0] c;
		input [2:0] s;
		input t;
		begin
			entry = {`K_END, `A_NONE};
			if (s == 3'h0)
				entry = {`K_OPF1, `A_PC};
			else
			begin
				case (c)
					`C_JR, `C_JRC:
					begin
						if (s == 3'h1)
							entry = {`K_OPR, `A_PC};
						else if (s < 3'h4 && (c == `C_JR || t))
							entry = {`K_IDLE, `A_NONE};
					end
					`C_LD_GG:
						if (s == 3'h1)
							entry = {`K_IDLE, `A_NONE};
					`C_LD_GM:
						if (s == 3'h1)
							entry = {`K_OPR, `A_PC};
					`C_LD_GHL:
						if (s == 3'h1)
							entry = {`K_RD, `A_HL};
					`C_LD_GIX, `C_LD_IXG:
					begin
						if (s == 3'h1)
							entry = {`K_OPF2, `A_PC};
						else if (s == 3'h2)
							entry = {`K_OPR, `A_PC};
						else if (s == 3'h5 && c == `C_LD_GIX)
							entry = {`K_RD, `A_IXD};
						else if (s == 3'h6 && c == `C_LD_IXG)
							entry = {`K_WR, `A_IXD};
						else if (s < 3'h6)
							entry = {`K_IDLE, `A_NONE};
					end
					`C_LD_HLG, `C_LD_BCA, `C_LD_DEA:
					begin
						if (s == 3'h1)
							entry = {`K_IDLE, `A_NONE};
						else if (s == 3'h2)
							entry = {`K_WR, (c == `C_LD_HLG) ? `A_HL :
								(c == `C_LD_BCA) ? `A_BC : `A_DE};
					end
					`C_LD_HLM:
					begin
						if (s == 3'h1)
							entry = {`K_OPR, `A_PC};
						else if (s == 3'h2)
							entry = {`K_WR, `A_HL};
					end
					`C_LD_IXM:
					begin
						if (s == 3'h1)
							entry = {`K_OPF2, `A_PC};
						else if (s < 3'h4)
							entry = {`K_OPR, `A_PC};
						else if (s == 3'h4)
							entry = {`K_WR, `A_IXD};
					end
					`C_LD_ABC, `C_LD_ADE:
						if (s == 3'h1)
							entry = {`K_RD,
								(c == `C_LD_ABC) ? `A_BC : `A_DE};
					`C_LD_AMN:
					begin
						if (s < 3'h3)
							entry = {`K_OPR, `A_PC};
						else if (s == 3'h3)
							entry = {`K_RD, `A_MN};
					end
					default:
						entry = {`K_END, `A_NONE};
				endcase
			end
			// unknown class has no opcode fetch either
			if (c == 4'hF)
				entry = {`K_END, `A_NONE};
		end
	endfunction

	wire [5:0] e;
	assign e = entry(cls, step, cond);
	assign kind = e[5:3];
	assign addr = e[2:0];

endmodule // cycle_table

`default_nettype wire

// File: core/bus_cycle_sequencer.v
// Purpose: orders bus and idle states of jumps and loads, drives strobes
// Assumes: instr_class and cond_true valid with instr_start
// Notes: all outputs registered; a request while busy is ignored
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

// Notes on behaviour
// - opcode fetch: rd, mem_request_n, first fetch, status low
// - prefixed second fetch: first fetch low, status high
// - operand fetch: plain three state memory read
// - idle state: all strobes high, data released
// - false conditional jump ends after displacement
// - true conditional jump adds two idle states
// - register move: fetch then one idle
// - load via HL: read at HL next
// - indexed load: two idles, read sixth cycle
// - store via HL: one idle, then write
// - indexed store: three idles, write seventh cycle
// - immediate via HL: operand, then write
// - immediate indexed: write in fifth cycle
// - accumulator via BC or DE: one read
// - direct load: two address bytes, read fourth
module bus_cycle_sequencer
(
	input wire mclk,
	input wire rst,
	input wire instr_start,
	input wire [3:0] instr_class,
	input wire cond_true,
	output reg rd_n,
	output reg wr_n,
	output reg mem_request_n,
	output reg io_request_n,
	output reg first_fetch_n,
	output reg halt_n,
	output reg cycle_status_out,
	output reg data_oe,
	output reg [2:0] addr_sel,
	output reg [2:0] t_state,
	output reg busy,
	output reg instr_done
);

	// ****************************************************************
	// timing and states
	// ****************************************************************

	// clocks per machine state, rounded up, never below one
	localparam integer STATE_CYC_RAW = (`STATE_TIME_PS + `CLK_PERIOD_PS - 1)
		/ `CLK_PERIOD_PS;
	localparam integer STATE_CYC = (STATE_CYC_RAW < 1) ? 1 : STATE_CYC_RAW;

	// one-hot machine states
	localparam [4:0] S_WAIT = 5'h01;
	localparam [4:0] S_T1 = 5'h02;
	localparam [4:0] S_T2 = 5'h04;
	localparam [4:0] S_T3 = 5'h08;
	localparam [4:0] S_TI = 5'h10;

	reg [4:0] state_q; // current machine state
	reg [4:0] state_d;
	reg [3:0] class_q; // latched instruction class
	reg [3:0] class_d;
	reg cond_q; // latched jump condition
	reg cond_d;
	reg [2:0] step_q; // machine cycle index, 0 = MC1
	reg [2:0] step_d;
	reg [2:0] kind_q; // kind of current machine cycle
	reg [2:0] kind_d;
	reg [2:0] asrc_q; // address source of current cycle
	reg [2:0] asrc_d;
	reg [7:0] dwell_q; // clocks spent in current state
	reg [7:0] dwell_d;
	reg done_d;

	// table lookup inputs: first cycle when waiting, else the next one
	wire waiting;
	wire [3:0] tab_cls;
	wire [2:0] tab_step;
	wire tab_cond;
	wire [2:0] tab_kind;
	wire [2:0] tab_addr;
	wire dwell_end;

	assign waiting = state_q[0];
	assign tab_cls = waiting ? instr_class : class_q;
	assign tab_step = waiting ? 3'h0 : step_q + 3'h1;
	assign tab_cond = waiting ? cond_true : cond_q;
	assign dwell_end = (dwell_q == STATE_CYC[7:0] - 8'h01);

	// ****************************************************************
	// cycle table
	// ****************************************************************
	cycle_table u_table
	(
		.cls(tab_cls),
		.step(tab_step),
		.cond(tab_cond),
		.kind(tab_kind),
		.addr(tab_addr)
	);

	// first state of a machine cycle of the given kind
	function [4:0] first_state;
		input [2:0] k;
		begin
			first_state = (k == `K_IDLE) ? S_TI : S_T1;
		end
	endfunction

	// ****************************************************************
	// sequencing
	// ****************************************************************

	// the table decides idle counts and cycle order per class
	always @*
	begin
		state_d = state_q;
		class_d = class_q;
		cond_d = cond_q;
		step_d = step_q;
		kind_d = kind_q;
		asrc_d = asrc_q;
		dwell_d = dwell_end ? 8'h00 : dwell_q + 8'h01;
		done_d = 1'b0;
		case (state_q)
			S_WAIT:
			begin
				dwell_d = 8'h00;
				// an unknown class yields END and is not started
				if (instr_start && tab_kind != `K_END)
				begin
					class_d = instr_class;
					cond_d = cond_true;
					step_d = 3'h0;
					kind_d = tab_kind;
					asrc_d = tab_addr;
					state_d = first_state(tab_kind);
				end
			end
			S_T1:
				if (dwell_end)
					state_d = S_T2;
			S_T2:
				if (dwell_end)
					state_d = S_T3;
			S_T3, S_TI:
			begin
				if (dwell_end)
				begin
					// false condition ends after MC2 in the table
					if (tab_kind == `K_END)
					begin
						state_d = S_WAIT;
						kind_d = `K_END;
						asrc_d = `A_NONE;
						done_d = 1'b1;
					end
					else
					begin
						// idle counts of jumps and loads come from table
						step_d = tab_step;
						kind_d = tab_kind;
						asrc_d = tab_addr;
						state_d = first_state(tab_kind);
					end
				end
			end
			default:
				state_d = S_WAIT;
		endcase
	end

	// ****************************************************************
	// registers and strobes
	// ****************************************************************

	// strobes follow the next state so they line up with it
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= S_WAIT;
			class_q <= 4'h0;
			cond_q <= 1'b0;
			step_q <= 3'h0;
			kind_q <= `K_END;
			asrc_q <= `A_NONE;
			dwell_q <= 8'h00;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			mem_request_n <= 1'b1;
			io_request_n <= 1'b1;
			first_fetch_n <= 1'b1;
			halt_n <= 1'b1;
			cycle_status_out <= 1'b1;
			data_oe <= 1'b0;
			addr_sel <= `A_NONE;
			t_state <= 3'h0;
			busy <= 1'b0;
			instr_done <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			class_q <= class_d;
			cond_q <= cond_d;
			step_q <= step_d;
			kind_q <= kind_d;
			asrc_q <= asrc_d;
			dwell_q <= dwell_d;
			// idle and wait keep every strobe high, data released
			if (state_d == S_WAIT || state_d == S_TI)
			begin
				rd_n <= 1'b1;
				wr_n <= 1'b1;
				mem_request_n <= 1'b1;
				first_fetch_n <= 1'b1;
				cycle_status_out <= 1'b1;
				data_oe <= 1'b0;
				addr_sel <= `A_NONE;
			end
			else
			begin
				// bus cycles: reads for opcode, operand and data fetches, a write for K_WR
				rd_n <= (kind_d == `K_WR);
				wr_n <= (kind_d != `K_WR);
				mem_request_n <= 1'b0;
				first_fetch_n <= !(kind_d == `K_OPF1 ||
					kind_d == `K_OPF2);
				cycle_status_out <= (kind_d != `K_OPF1);
				data_oe <= (kind_d == `K_WR);
				addr_sel <= asrc_d;
			end
			// no I/O cycles or halt in this group
			io_request_n <= 1'b1;
			halt_n <= 1'b1;
			t_state <= (state_d == S_T1) ? 3'h1 :
				(state_d == S_T2) ? 3'h2 :
				(state_d == S_T3) ? 3'h3 :
				(state_d == S_TI) ? 3'h4 : 3'h0;
			busy <= (state_d != S_WAIT);
			instr_done <= done_d;
		end
	end

endmodule // bus_cycle_sequencer

`default_nettype wire

// File: tb/seq_asserts.sv
// Purpose: timing checks on the sequencer ports
// Assumes: t_state 1..3 bus states, 4 idle
// Notes: bound to bus_cycle_sequencer below
`timescale 1ns/1ps
`default_nettype none
module seq_asserts
(
	input wire mclk,
	input wire rst,
	input wire instr_start,
	input wire [3:0] instr_class,
	input wire rd_n,
	input wire wr_n,
	input wire mem_request_n,
	input wire io_request_n,
	input wire first_fetch_n,
	input wire halt_n,
	input wire cycle_status_out,
	input wire data_oe,
	input wire [2:0] t_state,
	input wire busy,
	input wire instr_done
);
	// ********
	// checks
	// ********
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// a bus cycle walks through its three states in order
	sequence bus_tail;
		t_state == 3'h2 ##1 t_state == 3'h3;
	endsequence
	a_bus_three_states: assert property (t_state == 3'h1 |=> bus_tail)
		else $error("bus cycle not three states");
	a_fetch_strobes: assert property (
		t_state != 3'h4 && !first_fetch_n |->
		!rd_n && wr_n && !mem_request_n) else $error("bad fetch strobes");
	a_idle_high: assert property (t_state == 3'h4 |-> !data_oe &&
		&{rd_n, wr_n, mem_request_n, first_fetch_n, cycle_status_out})
		else $error("strobe low in idle");
	a_io_halt_high: assert property (io_request_n && halt_n)
		else $error("io request or halt low");
	// strobes must not wobble inside a bus cycle
	a_strobes_held: assert property (t_state inside {3'h2, 3'h3} |->
		$stable({rd_n, wr_n, mem_request_n, first_fetch_n, data_oe}))
		else $error("strobe changed in bus cycle");
	a_write_drive: assert property (!wr_n |-> data_oe && rd_n &&
		!mem_request_n) else $error("bad write strobes");
	a_status_first: assert property (!cycle_status_out |->
		!first_fetch_n) else $error("status low outside fetch");
	a_start_fetch: assert property (!busy && instr_start &&
		instr_class != 4'hF |=> t_state == 3'h1 && !cycle_status_out)
		else $error("start not followed by fetch");
	a_done_pulse: assert property ($fell(busy) |-> instr_done &&
		t_state == 3'h0) else $error("no done at end");
endmodule // seq_asserts
bind bus_cycle_sequencer seq_asserts chk (.mclk, .rst, .instr_start,
	.instr_class, .rd_n, .wr_n, .mem_request_n, .io_request_n,
	.first_fetch_n, .halt_n, .cycle_status_out, .data_oe, .t_state,
	.busy, .instr_done);
`default_nettype wire

// File: tb/ext_memory.sv
// Purpose: external memory seen from the bus
// Assumes: one transfer per T1
// Notes: counts transfers only, no data path at the ports
`timescale 1ns/1ps
`default_nettype none
module ext_memory
(
	input wire mclk,
	input wire rst,
	input wire rd_n,
	input wire wr_n,
	input wire mem_request_n,
	input wire [2:0] t_state,
	output logic [15:0] reads,
	output logic [15:0] writes
);
	// count at T1 so a cycle is never counted twice
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			reads <= 16'h0000;
			writes <= 16'h0000;
		end
		else if (t_state == 3'h1 && !mem_request_n)
		begin
			reads <= reads + {15'h0000, !rd_n};
			writes <= writes + {15'h0000, !wr_n};
		end
	end
endmodule // ext_memory
`default_nettype wire

// File: tb/bus_cycle_sequencer_tb.sv
// Purpose: self-checking bench of the bus cycle sequencer
// Assumes: one state per mclk at 200 MHz
// Notes: F G O R W i name fetch, fetch2, operand, read, write, idle
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"
module bus_cycle_sequencer_tb;
	logic mclk, rst, instr_start, cond_true;
	logic [3:0] instr_class;
	wire rd_n, wr_n, mem_request_n, io_request_n, first_fetch_n, halt_n;
	wire cycle_status_out, data_oe, busy, instr_done;
	wire [2:0] addr_sel, t_state;
	wire [15:0] reads, writes;
	int fail_count, samples_checked;
	logic [15:0] n_rd, n_wr; // expected transfer counts
	wire [15:0] vec = {rd_n, wr_n, mem_request_n, io_request_n,
		first_fetch_n, halt_n, cycle_status_out, data_oe, addr_sel,
		t_state, busy, instr_done};
	bus_cycle_sequencer uut (.mclk, .rst, .instr_start, .instr_class,
		.cond_true, .rd_n, .wr_n, .mem_request_n, .io_request_n,
		.first_fetch_n, .halt_n, .cycle_status_out, .data_oe, .addr_sel,
		.t_state, .busy, .instr_done);
	ext_memory mem (.mclk, .rst, .rd_n, .wr_n, .mem_request_n, .t_state,
		.reads, .writes);
	// ********
	// helpers
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// strobe byte for one cycle kind, data_oe last
	function automatic logic [7:0] strobes(input byte k);
		case (k)
			"F": return 8'h54;
			"G": return 8'h56;
			"W": return 8'h9F;
			"i": return 8'hFE;
			default: return 8'h5E;
		endcase
	endfunction
	// start stays high one edge past the take, so a busy refusal is seen
	task automatic run(input logic [3:0] c, input logic cd, input string s,
		input logic [2:0] a);
		logic [2:0] as;
		logic [15:0] ex;
		@(posedge mclk);
		instr_start <= 1'b1;
		instr_class <= c;
		cond_true <= cd;
		@(posedge mclk);
		for (int i = 0; i < s.len(); i++)
		begin
			as = (s[i] == "R" || s[i] == "W") ? a : 3'(s[i] != "i");
			if (s[i] == "W")
				n_wr++;
			else if (s[i] != "i")
				n_rd++;
			for (int t = 1; t <= 3; t++)
			begin
				if (s[i] == "i" && t > 1)
					break;
				ex = {strobes(s[i]), as, 3'(t), 2'h2};
				// an idle state shows t_state 4 instead of a bus state
				if (s[i] == "i")
					ex[4:2] = 3'h4;
				#1 chk(vec, ex);
				@(posedge mclk);
				instr_start <= 1'b0;
			end
		end
		#1 chk(vec, 16'hFE01);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_jumps;
		run(`C_JR, 1'b0, "FOii", 3'h0);
		run(`C_JRC, 1'b0, "FO", 3'h0);
		run(`C_JRC, 1'b1, "FOii", 3'h0);
		$display("test jumps done");
	endtask
	task automatic t_reads;
		run(`C_LD_GG, 1'b0, "Fi", 3'h0);
		run(`C_LD_GM, 1'b0, "FO", 3'h0);
		run(`C_LD_GHL, 1'b0, "FR", `A_HL);
		run(`C_LD_GIX, 1'b0, "FGOiiR", `A_IXD);
		run(`C_LD_ABC, 1'b0, "FR", `A_BC);
		run(`C_LD_ADE, 1'b0, "FR", `A_DE);
		run(`C_LD_AMN, 1'b0, "FOOR", `A_MN);
		$display("test reads done");
	endtask
	task automatic t_writes;
		run(`C_LD_HLG, 1'b0, "FiW", `A_HL);
		run(`C_LD_IXG, 1'b0, "FGOiiiW", `A_IXD);
		run(`C_LD_HLM, 1'b0, "FOW", `A_HL);
		run(`C_LD_IXM, 1'b0, "FGOOW", `A_IXD);
		run(`C_LD_BCA, 1'b0, "FiW", `A_BC);
		run(`C_LD_DEA, 1'b0, "FiW", `A_DE);
		$display("test writes done");
	endtask
	// invalid class must leave the bus idle
	task automatic t_refused;
		@(posedge mclk);
		instr_start <= 1'b1;
		instr_class <= 4'hF;
		repeat (3) @(posedge mclk);
		#1 chk(vec, 16'hFE00);
		chk(reads, n_rd);
		chk(writes, n_wr);
		$display("test refused done");
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// about 180 cycles are needed; the limit leaves wide margin
	initial
	begin
		#20000;
		fail_count++;
		tally_and_finish;
	end
	initial
	begin
		rst = 1'b1;
		instr_start = 1'b0;
		instr_class = 4'h0;
		cond_true = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		n_rd = 16'h0000;
		n_wr = 16'h0000;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		#1 chk(vec, 16'hFE00);
		t_jumps;
		t_reads;
		t_writes;
		t_refused;
		tally_and_finish;
	end
endmodule // bus_cycle_sequencer_tb
`default_nettype wire
